//--- hdl/psu_ctrl_pkg.sv
// constants shared by the psu output fault and restart controller
package psu_ctrl_pkg;
    // timing base: one tick is one millisecond
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_NS = 1000000;
    localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;
    localparam int STARTUP_GRACE_S = 20;
    localparam int RESTART_DELAY_S = 1;
    localparam int OV_WINDOW_S = 60;
    localparam int OFF_HOLD_S = 2;
    localparam logic [15:0] STARTUP_GRACE_TICKS = 16'(STARTUP_GRACE_S * 1000);
    localparam logic [15:0] RESTART_DELAY_TICKS = 16'(RESTART_DELAY_S * 1000);
    localparam logic [15:0] OV_WINDOW_TICKS = 16'(OV_WINDOW_S * 1000);
    localparam logic [15:0] OFF_HOLD_TICKS = 16'(OFF_HOLD_S * 1000);
    localparam logic [1:0] OV_LATCH_COUNT = 2'd3;
    // blink half period in ticks, as a bit index of the tick counter
    localparam int BLINK_BIT = 8;
    // bus address layout
    localparam logic [3:0] BUS_ADDR_UPPER = 4'hc;
    localparam logic [6:0] BUS_ADDR_BCAST = 7'h00;
    // apb register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] VSET_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    localparam logic [7:0] ALARM_OFS = 8'h0c;
    localparam logic [7:0] ADDR_OFS = 8'h10;
    // control register fields
    localparam int CTRL_OPON = 0;
    localparam int CTRL_MARGIN = 1;
    localparam int CTRL_OC_LATCH = 2;
    localparam int CTRL_OT_LATCH = 3;
    localparam int CTRL_OL_LATCH = 4;
    localparam logic [4:0] CTRL_RESET = 5'h01;
    // alarm register fields
    localparam int ALM_OV = 0;
    localparam int ALM_OC = 1;
    localparam int ALM_OT = 2;
    localparam int ALM_OL = 3;
    localparam int ALM_INVALID = 4;
    localparam int ALM_RESTART_OK = 5;
    localparam logic [7:0] VSET_RESET = 8'h80;
    typedef enum logic [1:0] {OUT_OFF, OUT_ON, OUT_DELAY,
        OUT_LATCHED} out_state_t;
endpackage

//--- hdl/psu_output_fault_restart_control.sv
// output enable, fault restart, latch-off, led and address decode logic
//
// Contract
// - pin rules until bus command, then ignored
// - startup overload held up to 20 seconds
// - limit above 10V keeps led blinking
// - limit below 10V in restart mode hiccups
// - led on when on, off otherwise
// - oc/ot default auto restart, configurable latch
// - ov restarts after 1s, three latch off
// - under three ov per minute resets count
// - five ways release latch-off
// - release needs off held two seconds
// - restart success clears alarms, sets flag
// - address is 1100 plus three straps
// - straps read high when left open
// - address lsb selects write or read
// - broadcast address zero accepts writes
// - broadcast read flags invalid command
// - margin command ignores pin until reset
// - pin or bus off turns output off
// - output needs interlock engaged
//
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/1ns
module psu_output_fault_restart_control
    import psu_ctrl_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
)(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic remoteOnPin,
    input wire logic interlockPinN,
    input wire logic unitInsertedPin,
    input wire logic address_strap_high,
    input wire logic address_strap_mid,
    input wire logic address_strap_low,
    input wire logic [7:0] vprogPinCode,
    input wire logic inLimitPin,
    input wire logic outAbove10Pin,
    input wire logic ovFaultPin,
    input wire logic ocFaultPin,
    input wire logic otFaultPin,
    input wire logic [7:0] busAddrByte,
    input wire logic busAddrValid,
    output logic busAddrAck,
    output logic busBroadcast,
    output logic mainOutEnable,
    output logic outLed,
    output logic [7:0] voltageSetCode
);
    localparam int NSYNC = 19;
    logic [NSYNC-1:0] syncA_reg;
    logic [NSYNC-1:0] syncB_reg;
    logic remoteOn, interlockOk, inserted, inLimit, above10;
    logic ovFault, ocFault, otFault;
    logic [2:0] strap;
    logic [7:0] vprogCode;
    logic [31:0] tickDiv_reg;
    logic tick_reg;
    logic [15:0] msCount_reg;
    logic [4:0] ctrl_reg;
    logic [7:0] vset_reg;
    logic [5:0] alarm_reg;
    logic swOwn_reg;
    out_state_t state_reg;
    logic [15:0] delayCnt_reg;
    logic [15:0] graceCnt_reg;
    logic graceDone_reg;
    logic [1:0] ovCount_reg;
    logic [15:0] ovWin_reg;
    logic [15:0] offCnt_reg;
    logic offSeen_reg;
    logic [2:0] faultPrev_reg;
    logic [31:0] rdata;
    logic apbSetup, apbDone, wrDone;
    logic selCtrl, selVset, selStatus, selAlarm, selAddr, mapped;
    logic [2:0] faultRise;
    logic olTrip, ocLatchReq, otLatchReq, olLatchReq, ovLatchReq;
    logic latchReq, restartReq, offRequest, offHeld, relCycle, relReconfig;
    logic allowOn, delayDone, restartOk, ledNext, invalidCmd;
    logic [6:0] ownAddr;
    logic addrOwnHit, addrBcastHit;

    // async pins go through two flops before use
    wire [NSYNC-1:0] pinVec = {remoteOnPin, interlockPinN, unitInsertedPin,
        address_strap_high, address_strap_mid, address_strap_low,
        vprogPinCode, inLimitPin, outAbove10Pin, ovFaultPin, ocFaultPin,
        otFaultPin};
    always_ff @(posedge clk or posedge sys_rst)
        if (sys_rst)
        begin
            syncA_reg <= '0;
            syncB_reg <= '0;
        end
        else if (ce)
        begin
            syncA_reg <= pinVec;
            syncB_reg <= syncA_reg;
        end
    assign remoteOn = syncB_reg[18];
    assign interlockOk = ~syncB_reg[17];
    assign inserted = syncB_reg[16];
    // straps are pulled up inside, so an open strap already arrives high
    assign strap = syncB_reg[15:13];
    assign vprogCode = syncB_reg[12:5];
    assign inLimit = syncB_reg[4];
    assign above10 = syncB_reg[3];
    assign ovFault = syncB_reg[2];
    assign ocFault = syncB_reg[1];
    assign otFault = syncB_reg[0];

    // millisecond tick keeps every long timer at 16 bits
    always_ff @(posedge clk or posedge sys_rst)
        if (sys_rst)
        begin
            tickDiv_reg <= '0;
            tick_reg <= 1'b0;
            msCount_reg <= '0;
        end
        else if (ce)
        begin
            tick_reg <= (tickDiv_reg == 32'(TICK_CYCLES - 1));
            tickDiv_reg <= (tickDiv_reg == 32'(TICK_CYCLES - 1)) ? '0
                : tickDiv_reg + 32'd1;
            if (tick_reg)
                msCount_reg <= msCount_reg + 16'd1;
        end

    // apb decode, one wait state on every access
    assign apbSetup = psel & penable & ~pready;
    assign apbDone = psel & penable & pready;
    assign selCtrl = (paddr == CTRL_OFS);
    assign selVset = (paddr == VSET_OFS);
    assign selStatus = (paddr == STATUS_OFS);
    assign selAlarm = (paddr == ALARM_OFS);
    assign selAddr = (paddr == ADDR_OFS);
    assign mapped = selCtrl | selVset | selStatus | selAlarm | selAddr;
    assign wrDone = apbDone & pwrite & mapped;
    assign ownAddr = {BUS_ADDR_UPPER, strap};
    assign rdata = selCtrl ? {27'h0, ctrl_reg}
        : selVset ? {24'h0, vset_reg}
        : selStatus ? {16'h0, ovCount_reg, graceDone_reg, swOwn_reg,
            mainOutEnable, outLed, state_reg, voltageSetCode}
        : selAlarm ? {26'h0, alarm_reg}
        : selAddr ? {25'h0, ownAddr}
        : 32'h0;

    always_ff @(posedge clk or posedge sys_rst)
        if (sys_rst)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end
        else if (ce)
        begin
            pready <= apbSetup;
            pslverr <= apbSetup & ~mapped;
            if (apbSetup)
                prdata <= pwrite ? 32'h0 : rdata;
        end

    // control and voltage set registers
    always_ff @(posedge clk or posedge sys_rst)
        if (sys_rst)
        begin
            ctrl_reg <= CTRL_RESET;
            vset_reg <= VSET_RESET;
            swOwn_reg <= 1'b0;
        end
        else if (ce)
        begin
            if (wrDone & selCtrl)
                ctrl_reg <= {pwdata[4:2], 1'b0, pwdata[0]};
            if (wrDone & selVset)
                vset_reg <= pwdata[7:0];
            // ownership only goes back to the pin on reset (bias cycle)
            if ((wrDone & selVset) | (wrDone & selCtrl & pwdata[CTRL_MARGIN]))
                swOwn_reg <= 1'b1;
        end

    // voltage setting follows the pin until software takes it
    always_ff @(posedge clk or posedge sys_rst)
        if (sys_rst)
            voltageSetCode <= VSET_RESET;
        else if (ce)
            voltageSetCode <= swOwn_reg ? vset_reg : vprogCode;

    // fault edges and overload protection after the startup grace
    assign faultRise = {ovFault, ocFault, otFault} & ~faultPrev_reg;
    assign olTrip = inLimit & graceDone_reg & ~above10;
    assign ocLatchReq = faultRise[1] & ctrl_reg[CTRL_OC_LATCH];
    assign otLatchReq = faultRise[0] & ctrl_reg[CTRL_OT_LATCH];
    assign olLatchReq = olTrip & ctrl_reg[CTRL_OL_LATCH];
    assign ovLatchReq = faultRise[2] & (ovCount_reg == OV_LATCH_COUNT - 2'd1);
    assign latchReq = ocLatchReq | otLatchReq | olLatchReq
        | ovLatchReq;
    assign restartReq = (faultRise[2] | faultRise[1] | faultRise[0]
        | (olTrip & ~ctrl_reg[CTRL_OL_LATCH])) & ~latchReq;

    // latch release: off held two seconds then back on, or reconfigured
    assign offRequest = ~remoteOn | ~ctrl_reg[CTRL_OPON] | ~inserted;
    assign offHeld = offCnt_reg >= OFF_HOLD_TICKS;
    assign relCycle = offSeen_reg & ~offRequest;
    assign relReconfig = wrDone & selCtrl
        & ~(pwdata[CTRL_OC_LATCH] | pwdata[CTRL_OT_LATCH]
        | pwdata[CTRL_OL_LATCH]);
    assign allowOn = remoteOn & interlockOk
        & ctrl_reg[CTRL_OPON];
    assign delayDone = (delayCnt_reg >= RESTART_DELAY_TICKS);

    always_ff @(posedge clk or posedge sys_rst)
        if (sys_rst)
        begin
            offCnt_reg <= '0;
            offSeen_reg <= 1'b0;
        end
        else if (ce)
        begin
            if (!offRequest)
                offCnt_reg <= '0;
            else if (tick_reg & ~offHeld)
                offCnt_reg <= offCnt_reg + 16'd1;
            // a short off pulse never arms the release
            if (state_reg != OUT_LATCHED)
                offSeen_reg <= 1'b0;
            else if (offRequest & offHeld)
                offSeen_reg <= 1'b1;
        end

    // output state machine
    always_ff @(posedge clk or posedge sys_rst)
        if (sys_rst)
        begin
            state_reg <= OUT_OFF;
            delayCnt_reg <= '0;
            faultPrev_reg <= '0;
        end
        else if (ce)
        begin
            faultPrev_reg <= {ovFault, ocFault, otFault};
            case (state_reg)
                OUT_OFF:
                begin
                    delayCnt_reg <= '0;
                    if (allowOn)
                        state_reg <= OUT_ON;
                end
                OUT_ON:
                begin
                    delayCnt_reg <= '0;
                    if (latchReq)
                        state_reg <= OUT_LATCHED;
                    else if (restartReq)
                        state_reg <= OUT_DELAY;
                    else if (!allowOn)
                        state_reg <= OUT_OFF;
                end
                OUT_DELAY:
                begin
                    if (latchReq)
                        state_reg <= OUT_LATCHED;
                    else if (delayDone & ~(ovFault | ocFault | otFault))
                        state_reg <= allowOn ? OUT_ON : OUT_OFF;
                    else if (tick_reg & ~delayDone)
                        delayCnt_reg <= delayCnt_reg + 16'd1;
                end
                OUT_LATCHED:
                begin
                    delayCnt_reg <= '0;
                    if (relCycle | relReconfig)
                        state_reg <= OUT_OFF;
                end
                default:
                    state_reg <= OUT_OFF;
            endcase
        end

    // startup grace: overload rides in constant current up to 20 s
    always_ff @(posedge clk or posedge sys_rst)
        if (sys_rst)
        begin
            graceCnt_reg <= '0;
            graceDone_reg <= 1'b0;
        end
        else if (ce)
        begin
            if (state_reg == OUT_OFF)
            begin
                graceCnt_reg <= '0;
                graceDone_reg <= 1'b0;
            end
            else if (tick_reg & ~graceDone_reg)
            begin
                graceCnt_reg <= graceCnt_reg + 16'd1;
                graceDone_reg <= (graceCnt_reg
                    >= STARTUP_GRACE_TICKS - 16'd1);
            end
        end

    // overvoltage counting within a one minute window
    always_ff @(posedge clk or posedge sys_rst)
        if (sys_rst)
        begin
            ovCount_reg <= '0;
            ovWin_reg <= '0;
        end
        else if (ce)
        begin
            if (state_reg == OUT_LATCHED)
            begin
                ovCount_reg <= '0;
                ovWin_reg <= '0;
            end
            else if (faultRise[2])
                ovCount_reg <= ovCount_reg + 2'd1;
            else if (ovCount_reg != 2'd0 && ovWin_reg >= OV_WINDOW_TICKS)
            begin
                ovCount_reg <= '0;
                ovWin_reg <= '0;
            end
            else if (ovCount_reg != 2'd0 && tick_reg)
                ovWin_reg <= ovWin_reg + 16'd1;
        end

    // alarms: hardware set wins over software write-one-clear
    assign restartOk = (state_reg == OUT_DELAY) & delayDone
        & ~(ovFault | ocFault | otFault) & allowOn;
    assign addrOwnHit = busAddrValid & (busAddrByte[7:1] == ownAddr);
    assign addrBcastHit = busAddrValid & (busAddrByte[7:1] == BUS_ADDR_BCAST);
    // lsb 1 is a read, never legal at the broadcast address
    assign invalidCmd = addrBcastHit & busAddrByte[0];
    always_ff @(posedge clk or posedge sys_rst)
        if (sys_rst)
            alarm_reg <= '0;
        else if (ce)
        begin
            if (restartOk)
                alarm_reg <= 6'(1 << ALM_RESTART_OK);
            else
                alarm_reg <= (alarm_reg
                    & ~((wrDone & selAlarm) ? pwdata[5:0] : 6'h0))
                    | {1'b0, invalidCmd, olTrip, faultRise[0],
                    faultRise[1], faultRise[2]};
        end

    // address acknowledge: own address either way, broadcast writes only
    always_ff @(posedge clk or posedge sys_rst)
        if (sys_rst)
        begin
            busAddrAck <= 1'b0;
            busBroadcast <= 1'b0;
        end
        else if (ce)
        begin
            busAddrAck <= addrOwnHit
                | (addrBcastHit & ~busAddrByte[0]);
            busBroadcast <= addrBcastHit & ~busAddrByte[0];
        end

    // led: blink in limit above 10V, off when off or latched
    assign ledNext = (state_reg != OUT_ON) ? 1'b0
        : (inLimit & above10) ? msCount_reg[BLINK_BIT] : 1'b1;
    always_ff @(posedge clk or posedge sys_rst)
        if (sys_rst)
        begin
            outLed <= 1'b0;
            mainOutEnable <= 1'b0;
        end
        else if (ce)
        begin
            outLed <= ledNext;
            mainOutEnable <= (state_reg == OUT_ON) & allowOn;
        end
endmodule // psu_output_fault_restart_control

//--- sim/psu_ctrl_assertions.sv
// concurrent checks on the output controller ports
`timescale 1ns/1ns
module psu_ctrl_assertions
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic remoteOnPin,
    input wire logic interlockPinN,
    input wire logic [7:0] busAddrByte,
    input wire logic busAddrValid,
    input wire logic busAddrAck,
    input wire logic busBroadcast,
    input wire logic mainOutEnable,
    input wire logic outLed
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    a_access_wait: assert property (psel && penable && !pready
        && !$past(penable) |=> pready)
        else $error("no answer one cycle into access");
    a_pready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_unmapped_err: assert property (pready && paddr > 8'h10 |-> pslverr)
        else $error("unmapped access without error");
    a_bcast_write: assert property (busAddrValid
        && busAddrByte == 8'h00 |=> busAddrAck && busBroadcast)
        else $error("broadcast write not taken");
    a_bcast_read: assert property (busAddrValid
        && busAddrByte == 8'h01 |=> !busAddrAck && !busBroadcast)
        else $error("broadcast read acknowledged");
    a_ack_upper: assert property (busAddrAck
        |-> $past(busAddrValid) && ($past(busAddrByte[7:4]) == 4'hc
        || $past(busAddrByte) == 8'h00))
        else $error("ack for a foreign address");
    a_interlock_off: assert property (interlockPinN [*6]
        |-> !mainOutEnable)
        else $error("output on with interlock open");
    a_remote_off: assert property (!remoteOnPin [*6]
        |-> !mainOutEnable && !outLed)
        else $error("output or led on with remote off");
endmodule // psu_ctrl_assertions

//--- sim/host_addr_model.sv
// host side model presenting address bytes to the controller
`timescale 1ns/1ns
module host_addr_model
(
    input wire logic clk,
    input wire logic busAddrAck,
    input wire logic busBroadcast,
    output logic [7:0] busAddrByte,
    output logic busAddrValid
);
    initial
    begin
        busAddrByte = 8'h5a;
        busAddrValid = 1'b0;
    end
    // lsb of the byte is the direction bit
    task automatic send(input logic [7:0] b, output logic ack,
        output logic bc);
        @(posedge clk);
        busAddrByte <= b;
        busAddrValid <= 1'b1;
        @(posedge clk);
        busAddrValid <= 1'b0;
        // inverse of the last byte, so a stale byte is never mistaken
        busAddrByte <= ~b;
        // the answer stands for the cycle after the byte; take it at its end
        @(posedge clk);
        ack = busAddrAck;
        bc = busBroadcast;
    endtask
endmodule // host_addr_model

//--- sim/psu_output_fault_restart_control_bench.sv
// directed bench for the output fault and restart controller
`timescale 1ns/1ns
module psu_output_fault_restart_control_bench;
    import psu_ctrl_pkg::*;
    // short tick keeps the second-long timers within the run
    localparam int TC = 1;
    logic clk, sys_rst, ce, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr, vprogPinCode, busAddrByte, voltageSetCode;
    logic [31:0] pwdata, prdata, rd;
    logic remoteOnPin, interlockPinN, unitInsertedPin, inLimitPin;
    logic address_strap_high, address_strap_mid, address_strap_low;
    logic outAbove10Pin, ovFaultPin, ocFaultPin, otFaultPin;
    logic busAddrValid, busAddrAck, busBroadcast, mainOutEnable, outLed;
    logic ack, bc, sawHi, sawLo;
    logic [7:0] ab [5] = '{8'hc4, 8'hc5, 8'hc6, 8'h00, 8'h01};
    logic [1:0] ax [5] = '{2'b10, 2'b10, 2'b00, 2'b11, 2'b00};
    int failures = 0;
    int n_compared = 0;
    int cyc = 0;
    psu_output_fault_restart_control #(.TICK_CYCLES(TC)) dut (.clk,
        .sys_rst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .remoteOnPin, .interlockPinN,
        .unitInsertedPin, .address_strap_high, .address_strap_mid,
        .address_strap_low, .vprogPinCode, .inLimitPin, .outAbove10Pin,
        .ovFaultPin, .ocFaultPin, .otFaultPin, .busAddrByte,
        .busAddrValid, .busAddrAck, .busBroadcast, .mainOutEnable,
        .outLed, .voltageSetCode);
    host_addr_model host (.clk, .busAddrAck, .busBroadcast, .busAddrByte,
        .busAddrValid);
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic stop_test();
        $display("failures %0d compared %0d", failures, n_compared);
        if (failures == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            failures++;
            stop_test();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // only the bench timeout ends a wait for the answer
        do
            @(posedge clk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask
    task automatic hold(input int n);
        repeat (n) @(posedge clk);
    endtask
    // bounded wait; a missing change shows up as a mismatch
    task automatic wait_en(input logic v, input int m);
        int n;
        n = 0;
        while (mainOutEnable !== v && n < m)
        begin
            @(posedge clk);
            n++;
        end
        check({31'h0, mainOutEnable}, {31'h0, v});
    endtask
    task automatic pulse_ov();
        ovFaultPin <= 1'b1;
        hold(1);
        ovFaultPin <= 1'b0;
    endtask
    initial
    begin
        {sys_rst, ce, remoteOnPin, unitInsertedPin} = 4'hf;
        {psel, penable, pwrite, interlockPinN} = 4'h0;
        {paddr, pwdata} = 40'h0;
        {address_strap_high, address_strap_mid, address_strap_low} = 3'h7;
        vprogPinCode = 8'h55;
        {inLimitPin, outAbove10Pin, ovFaultPin, ocFaultPin} = 4'h0;
        otFaultPin = 1'b0;
        hold(16);
        sys_rst <= 1'b0;
        rdchk(ADDR_OFS, 32'h67);
        rdchk(CTRL_OFS, 32'h1);
        apb(1'b0, 8'h14, 32'h0);
        check({rd[30:0], err}, 32'h1);
        check({24'h0, voltageSetCode}, 32'h55);
        wait_en(1'b1, 20);
        check({31'h0, outLed}, 32'h1);
        interlockPinN <= 1'b1;
        wait_en(1'b0, 10);
        interlockPinN <= 1'b0;
        wait_en(1'b1, 10);
        remoteOnPin <= 1'b0;
        wait_en(1'b0, 10);
        hold(2);
        check({31'h0, outLed}, 32'h0);
        remoteOnPin <= 1'b1;
        wait_en(1'b1, 10);
        apb(1'b1, CTRL_OFS, 32'h0);
        wait_en(1'b0, 10);
        hold(20000 * TC);
        apb(1'b1, CTRL_OFS, 32'h1);
        wait_en(1'b1, 10);
        {address_strap_high, address_strap_mid, address_strap_low} <= 3'h2;
        hold(4);
        rdchk(ADDR_OFS, 32'h62);
        for (int i = 0; i < 5; i++)
        begin
            host.send(ab[i], ack, bc);
            check({30'h0, ack, bc}, {30'h0, ax[i]});
        end
        // clock enable low freezes the address acknowledge
        ce <= 1'b0;
        host.send(8'hc4, ack, bc);
        check({30'h0, ack, bc}, 32'h0);
        ce <= 1'b1;
        rdchk(ALARM_OFS, 32'h10);
        apb(1'b1, ALARM_OFS, 32'h10);
        rdchk(ALARM_OFS, 32'h0);
        apb(1'b1, VSET_OFS, 32'h33);
        vprogPinCode <= 8'h77;
        hold(6);
        check({24'h0, voltageSetCode}, 32'h33);
        inLimitPin <= 1'b1;
        outAbove10Pin <= 1'b1;
        {sawHi, sawLo} = 2'b00;
        repeat (2 * 256 * TC + 100)
        begin
            @(posedge clk);
            sawHi |= outLed;
            sawLo |= ~outLed;
        end
        check({30'h0, sawHi, sawLo}, 32'h3);
        inLimitPin <= 1'b0;
        ocFaultPin <= 1'b1;
        wait_en(1'b0, 10);
        ocFaultPin <= 1'b0;
        rdchk(ALARM_OFS, 32'h2);
        wait_en(1'b1, 1000 * TC + 20);
        hold(2);
        rdchk(ALARM_OFS, 32'h20);
        for (int i = 0; i < 3; i++)
        begin
            pulse_ov();
            wait_en(1'b0, 10);
            hold(990 * TC);
            check({31'h0, mainOutEnable}, 32'h0);
            if (i < 2)
                wait_en(1'b1, 30 * TC);
        end
        hold(110 * TC);
        apb(1'b0, STATUS_OFS, 32'h0);
        check({29'h0, rd[10:8]}, 32'h3);
        rdchk(ALARM_OFS, 32'h21);
        remoteOnPin <= 1'b0;
        hold(1000 * TC);
        remoteOnPin <= 1'b1;
        hold(200 * TC);
        check({31'h0, mainOutEnable}, 32'h0);
        remoteOnPin <= 1'b0;
        hold(2050 * TC);
        remoteOnPin <= 1'b1;
        wait_en(1'b1, 20);
        apb(1'b1, CTRL_OFS, 32'h5);
        ocFaultPin <= 1'b1;
        hold(1);
        ocFaultPin <= 1'b0;
        hold(1100 * TC);
        check({31'h0, mainOutEnable}, 32'h0);
        apb(1'b1, CTRL_OFS, 32'h1);
        wait_en(1'b1, 20);
        // bias cycle: default setting, pin owns the voltage again
        sys_rst <= 1'b1;
        hold(4);
        check({24'h0, voltageSetCode}, {24'h0, VSET_RESET});
        check({31'h0, mainOutEnable}, 32'h0);
        sys_rst <= 1'b0;
        hold(6);
        check({24'h0, voltageSetCode}, 32'h77);
        rdchk(CTRL_OFS, 32'h1);
        wait_en(1'b1, 20);
        // overload below 10V rides the grace, then hiccups
        outAbove10Pin <= 1'b0;
        inLimitPin <= 1'b1;
        hold(19900 * TC);
        check({31'h0, mainOutEnable}, 32'h1);
        wait_en(1'b0, 200 * TC);
        apb(1'b0, STATUS_OFS, 32'h0);
        check({30'h0, rd[9:8]}, 32'h2);
        stop_test();
    end
endmodule // psu_output_fault_restart_control_bench
bind psu_output_fault_restart_control psu_ctrl_assertions chk (.clk,
    .sys_rst, .psel, .penable, .paddr, .pready, .pslverr, .remoteOnPin,
    .interlockPinN, .busAddrByte, .busAddrValid, .busAddrAck,
    .busBroadcast, .mainOutEnable, .outLed);
